// ---- src/cpe_consts.vh ----
`ifndef CPE_CONSTS_VH
`define CPE_CONSTS_VH
// ==========================================
// register byte offsets
`define CPE_REG_CONTROL0    8'h00
`define CPE_REG_CONTROL1    8'h04
`define CPE_REG_RISE_EN     8'h08
`define CPE_REG_FALL_EN     8'h0C
`define CPE_REG_RISE_EDGE   8'h10
`define CPE_REG_FALL_EDGE   8'h14
`define CPE_REG_STEERING    8'h18
`define CPE_REG_RISE_DB     8'h1C
`define CPE_REG_FALL_DB     8'h20
`define CPE_REG_STATUS      8'h24
// ==========================================
// field positions
`define CPE_CTL0_EN         0
`define CPE_CTL0_MODE_LSB   1
`define CPE_CTL0_CS_LSB     4
`define CPE_CTL1_RDB        0
`define CPE_CTL1_FDB        1
`define CPE_CTL1_POL_LSB    4
// ==========================================
// reset values
`define CPE_RST_BYTE        8'h00
`define CPE_RST_COUNT       6'h00
// ==========================================
// operating modes
`define CPE_MD_STEER        3'h0
`define CPE_MD_SYNC_STEER   3'h1
`define CPE_MD_FWD          3'h2
`define CPE_MD_REV          3'h3
`define CPE_MD_HALF         3'h4
`define CPE_MD_PUSH_PULL    3'h5
// ==========================================
// reference clock select
`define CPE_CS_SYS          2'h0
`define CPE_CS_INSTR        2'h1
`define CPE_CS_OSC          2'h2
// ==========================================
// shutdown override codes
`define CPE_OVR_INACTIVE    2'h0
`define CPE_OVR_HIZ         2'h1
`define CPE_OVR_LOW         2'h2
`define CPE_OVR_HIGH        2'h3
// ==========================================
// timing
`define CPE_CLK_PERIOD_NS   10
`define CPE_CHAIN_ELEM_NS   5
// ==========================================
// bus responses
`define CPE_RESP_OKAY       2'h0
`define CPE_RESP_SLVERR     2'h2
`endif

// ---- src/cpe_event_in.v ----
`timescale 1ns/1ps
module cpe_event_in (
	input  wire       aclk,
	input  wire       aresetn,
	input  wire [7:0] sources,
	input  wire [7:0] enables,
	input  wire [7:0] edge_modes,
	input  wire       blank,
	output wire       fire
);
	reg  [7:0] src_d;
	reg        comb_d;
	wire [7:0] hit;
	wire       comb;
	genvar     i;

	// ==========================================
	// per-source sensing
	generate
		for (i = 0; i < 8; i = i + 1)
		begin : g_src
			assign hit[i] = enables[i] & (edge_modes[i] ? // see R3, R4
				(sources[i] & ~src_d[i]) : sources[i]);
		end
	endgenerate

	assign comb = (|hit) & ~blank; // see R3
	assign fire = comb & ~comb_d;  // see R6, R9

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			src_d  <= 8'h00;
			comb_d <= 1'b0;
		end
		else
		begin
			src_d  <= sources;
			comb_d <= comb;
		end
	end
endmodule

// ---- src/cpe_deadband.v ----
`timescale 1ns/1ps
`include "cpe_consts.vh"
module cpe_deadband (
	input  wire       aclk,
	input  wire       aresetn,
	input  wire       start,
	input  wire       abort,
	input  wire [5:0] count,
	input  wire       use_counter,
	input  wire       ref_tick,
	output reg        busy,
	output wire       done
);
	reg  [8:0]  cnt;
	reg  [8:0]  target;
	reg         by_ref;
	wire        zero;
	wire        inc;
	wire        finish;
	wire [31:0] chain_t;

	// ==========================================
	// delay chain emulated in whole clock cycles
	assign chain_t = ({26'h0, count} * `CPE_CHAIN_ELEM_NS // see R18, R20
		+ `CPE_CLK_PERIOD_NS - 1) / `CPE_CLK_PERIOD_NS;
	assign zero   = (count == 6'h00); // see R18, R19
	assign inc    = busy & (by_ref ? ref_tick : 1'b1); // see R2, R19
	assign finish = inc & ((cnt + 9'h001) == target);
	assign done   = (start & zero) | (finish & ~abort & ~start);

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			busy   <= 1'b0;
			cnt    <= 9'h000;
			target <= 9'h000;
			by_ref <= 1'b0;
		end
		else if (start)
		begin
			busy   <= ~zero;
			cnt    <= 9'h000;
			target <= use_counter ? {3'h0, count} : chain_t[8:0]; // see R15
			by_ref <= use_counter;
		end
		else if (abort || finish)
			busy <= 1'b0;
		else if (inc)
			cnt <= cnt + 9'h001;
	end
endmodule

// ---- src/cpe_top.v ----
`timescale 1ns/1ps
`include "cpe_consts.vh"
// What this block does
// R1: reference tick from system clock, clock/4 or internal osc tick
// R2: counter-mode dead-band and blanking/phase neighbours time from the reference tick
// R3: per-source enable bits; enabled sources ORed per category
// R4: per-source mode bit, one means edge, zero means level
// R5: software should use edge for periodic, level for threshold sources
// R6: rising combined-event edge starts active period, immediate at zero
// R7: rise clears complementary, starts blanking and dead-band, sets primary
// R8: fall clears primary, starts blanking and dead-band, sets complementary
// R9: falling combined-event edge ends active period, immediate at zero
// R10: disabled or just enabled: primary inactive, complementary active
// R11: output is static data, shutdown override, inactive or active PWM
// R12: no output enables; all four outputs offered to every pin
// R13: per-output polarity; among overrides only inactive state obeys it
// R14: dead time only in half-bridge and full-bridge direction change
// R15: rising and falling timers each pick delay chain or counter
// R16: half-bridge delays A/C by rise time, B/D by fall time
// R17: full-bridge delays modulated output on direction change
// R18: chain mode delays count elements of five ns, zero disables
// R19: counter mode counts reference ticks to the count, zero disables
// R20: counter mode may vary a tick on async inputs; chain avoids it
// R21: rise dead-band holds off primary, fall dead-band complementary
// R22: overlapping opposite event aborts running dead-band and starts its own
// R23: three-bit mode field decodes the six operating modes
module cpe_top (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire [7:0]  rise_sources,
	input  wire [7:0]  fall_sources,
	input  wire        internal_fast_osc,
	input  wire        blank_rise_inputs,
	input  wire        blank_fall_inputs,
	input  wire        rise_phase_fire,
	input  wire        fall_phase_fire,
	input  wire        shutdown_active,
	input  wire [1:0]  override_ac,
	input  wire [1:0]  override_bd,
	output wire        out_a,
	output wire        out_b,
	output wire        out_c,
	output wire        out_d,
	output reg  [3:0]  out_hiz,
	output reg         gen_ref_clock,
	output reg         rise_event_pulse,
	output reg         fall_event_pulse,
	output reg         start_fall_blanking,
	output reg         start_rise_blanking
);
	reg  [5:0]  gen_control0;
	reg  [7:0]  gen_control1;
	reg  [7:0]  rise_source_enables;
	reg  [7:0]  fall_source_enables;
	reg  [7:0]  rise_source_edge_modes;
	reg  [7:0]  fall_source_edge_modes;
	reg  [7:0]  steering_bits;
	reg  [5:0]  rise_deadband_count;
	reg  [5:0]  fall_deadband_count;
	reg         aw_hold;
	reg         w_hold;
	reg  [7:0]  wr_addr;
	reg  [31:0] wr_data;
	reg  [3:0]  wr_strb;
	reg  [31:0] next_rdata;
	reg  [1:0]  next_rresp;
	reg  [1:0]  div;
	reg         ref_tick;
	reg         prim;
	reg         comp;
	reg         last_dir;
	reg         have_dir;
	reg         pp_phase;
	reg  [3:0]  steer_eff;
	reg  [3:0]  out_q;
	reg  [3:0]  pwm;
	wire        gen_enable_bit;
	wire [2:0]  operating_mode_field;
	wire [1:0]  ref_clock_select;
	wire [3:0]  polarity;
	wire        half;
	wire        full;
	wire        steered;
	wire        rise_raw;
	wire        fall_raw;
	wire        rise_go;
	wire        fall_go;
	wire        rdb_busy;
	wire        rdb_done;
	wire        fdb_busy;
	wire        fdb_done;
	wire        dir_busy;
	wire        dir_change;
	wire        dir_hold;
	wire [3:0]  inact;
	wire [3:0]  steer_use;
	wire [3:0]  next_out;
	wire [3:0]  next_hiz;
	genvar      i;

	assign gen_enable_bit       = gen_control0[`CPE_CTL0_EN];
	assign operating_mode_field = gen_control0[`CPE_CTL0_MODE_LSB +: 3];
	assign ref_clock_select     = gen_control0[`CPE_CTL0_CS_LSB +: 2];
	assign polarity             = gen_control1[`CPE_CTL1_POL_LSB +: 4];

	// ==========================================
	// mode decode
	assign half    = (operating_mode_field == `CPE_MD_HALF); // see R23
	assign full    = (operating_mode_field == `CPE_MD_FWD) ||
		(operating_mode_field == `CPE_MD_REV);
	assign steered = (operating_mode_field == `CPE_MD_STEER) ||
		(operating_mode_field == `CPE_MD_SYNC_STEER);

	// ==========================================
	// reference tick
	always @*
	begin
		case (ref_clock_select) // see R1
			`CPE_CS_SYS:   ref_tick = 1'b1;
			`CPE_CS_INSTR: ref_tick = (div == 2'h3);
			default:       ref_tick = internal_fast_osc;
		endcase
	end

	// ==========================================
	// event inputs
	cpe_event_in u_rise (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.sources    (rise_sources),
		.enables    (rise_source_enables),
		.edge_modes (rise_source_edge_modes),
		.blank      (blank_rise_inputs),
		.fire       (rise_raw)
	);

	cpe_event_in u_fall (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.sources    (fall_sources),
		.enables    (fall_source_enables),
		.edge_modes (fall_source_edge_modes),
		.blank      (blank_fall_inputs),
		.fire       (fall_raw)
	);

	assign rise_go = rise_phase_fire & gen_enable_bit;
	assign fall_go = fall_phase_fire & gen_enable_bit;

	// ==========================================
	// dead-band timers
	cpe_deadband u_rdb (
		.aclk        (aclk),
		.aresetn     (aresetn),
		.start       (rise_go & ~fall_go), // see R7, R21
		.abort       (fall_go), // see R22
		.count       (half ? rise_deadband_count : 6'h00), // see R14, R16
		.use_counter (gen_control1[`CPE_CTL1_RDB]), // see R15
		.ref_tick    (ref_tick), // see R2
		.busy        (rdb_busy),
		.done        (rdb_done)
	);

	cpe_deadband u_fdb (
		.aclk        (aclk),
		.aresetn     (aresetn),
		.start       (fall_go), // see R8, R21
		.abort       (rise_go & ~fall_go), // see R22
		.count       (half ? fall_deadband_count : 6'h00), // see R14, R16
		.use_counter (gen_control1[`CPE_CTL1_FDB]), // see R15
		.ref_tick    (ref_tick), // see R2
		.busy        (fdb_busy),
		.done        (fdb_done)
	);

	assign dir_change = gen_enable_bit & full & have_dir &
		(operating_mode_field[0] != last_dir);
	assign dir_hold   = dir_busy | dir_change; // see R17

	cpe_deadband u_dir (
		.aclk        (aclk),
		.aresetn     (aresetn),
		.start       (dir_change), // see R14, R17
		.abort       (~gen_enable_bit),
		.count       (operating_mode_field[0] ? fall_deadband_count :
			rise_deadband_count), // see R17
		.use_counter (operating_mode_field[0] ?
			gen_control1[`CPE_CTL1_FDB] : gen_control1[`CPE_CTL1_RDB]),
		.ref_tick    (ref_tick),
		.busy        (dir_busy),
		.done        ()
	);

	// ==========================================
	// drive state
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			div                 <= 2'h0;
			gen_ref_clock       <= 1'b0;
			rise_event_pulse    <= 1'b0;
			fall_event_pulse    <= 1'b0;
			start_fall_blanking <= 1'b0;
			start_rise_blanking <= 1'b0;
			last_dir            <= 1'b0;
			have_dir            <= 1'b0;
		end
		else
		begin
			div                 <= div + 2'h1;
			gen_ref_clock       <= ref_tick;
			rise_event_pulse    <= rise_raw & gen_enable_bit; // see R6
			fall_event_pulse    <= fall_raw & gen_enable_bit; // see R9
			start_fall_blanking <= rise_go; // see R7
			start_rise_blanking <= fall_go; // see R8
			last_dir            <= operating_mode_field[0];
			have_dir            <= full & gen_enable_bit;
		end
	end

	always @(posedge aclk)
	begin
		if (!aresetn || !gen_enable_bit)
		begin
			prim     <= 1'b0; // see R10
			comp     <= 1'b1; // see R10
			pp_phase <= 1'b0;
		end
		else
		begin
			if (fall_go)
				prim <= 1'b0; // see R8
			else if (rdb_done)
				prim <= 1'b1; // see R7, R21
			if (rise_go && !fall_go)
				comp <= 1'b0; // see R7, R22
			else if (fdb_done)
				comp <= 1'b1; // see R8, R21
			if (rise_go && operating_mode_field == `CPE_MD_PUSH_PULL)
				pp_phase <= ~pp_phase;
		end
	end

	always @(posedge aclk)
	begin
		if (!aresetn)
			steer_eff <= 4'h0;
		else if (operating_mode_field != `CPE_MD_SYNC_STEER || rise_go)
			steer_eff <= steering_bits[3:0];
	end

	// ==========================================
	// output composition
	always @*
	begin
		case (operating_mode_field) // see R23
			`CPE_MD_STEER,
			`CPE_MD_SYNC_STEER: pwm = {4{prim}};
			`CPE_MD_FWD:        pwm = {prim & ~dir_hold, 2'b00, 1'b1};
			`CPE_MD_REV:        pwm = {2'b01, prim & ~dir_hold, 1'b0};
			`CPE_MD_HALF:       pwm = {comp, prim, comp, prim}; // see R16
			`CPE_MD_PUSH_PULL:  pwm = pp_phase ? {prim, 1'b0, prim, 1'b0} :
				{1'b0, prim, 1'b0, prim};
			default:            pwm = 4'h0;
		endcase
	end

	assign inact     = half ? 4'b1010 : 4'b0000; // see R10
	assign steer_use = steered ? steer_eff : 4'hF;

	generate
		for (i = 0; i < 4; i = i + 1)
		begin : g_out
			wire [1:0] ovr;
			assign ovr = (i % 2 == 0) ? override_ac : override_bd;
			assign next_out[i] = !steer_use[i] ? steering_bits[4 + i] : // see R11
				shutdown_active ?
				((ovr == `CPE_OVR_INACTIVE) ? inact[i] ^ polarity[i] : // see R13
				(ovr == `CPE_OVR_HIGH)) :
				!gen_enable_bit ? inact[i] ^ polarity[i] :
				pwm[i] ^ polarity[i]; // see R13
			assign next_hiz[i] = steer_use[i] & shutdown_active &
				(ovr == `CPE_OVR_HIZ);
		end
	endgenerate

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			out_q   <= 4'h0;
			out_hiz <= 4'h0;
		end
		else
		begin
			out_q   <= next_out;
			out_hiz <= next_hiz;
		end
	end

	assign out_a = out_q[0]; // see R12
	assign out_b = out_q[1];
	assign out_c = out_q[2];
	assign out_d = out_q[3];

	// ==========================================
	// register bus
	assign s_axi_awready = ~aw_hold & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_hold & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_hold                <= 1'b0;
			w_hold                 <= 1'b0;
			wr_addr                <= 8'h00;
			wr_data                <= 32'h00000000;
			wr_strb                <= 4'h0;
			s_axi_bvalid           <= 1'b0;
			s_axi_bresp            <= `CPE_RESP_OKAY;
			gen_control0           <= 6'h00;
			gen_control1           <= `CPE_RST_BYTE;
			rise_source_enables    <= `CPE_RST_BYTE;
			fall_source_enables    <= `CPE_RST_BYTE;
			rise_source_edge_modes <= `CPE_RST_BYTE;
			fall_source_edge_modes <= `CPE_RST_BYTE;
			steering_bits          <= `CPE_RST_BYTE;
			rise_deadband_count    <= `CPE_RST_COUNT;
			fall_deadband_count    <= `CPE_RST_COUNT;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_hold <= 1'b1;
				wr_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_hold  <= 1'b1;
				wr_data <= s_axi_wdata;
				wr_strb <= s_axi_wstrb;
			end
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (aw_hold && w_hold && !s_axi_bvalid)
			begin
				aw_hold      <= 1'b0;
				w_hold       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= `CPE_RESP_OKAY;
				if (wr_strb[0])
				begin
					case (wr_addr)
						`CPE_REG_CONTROL0:  gen_control0 <= wr_data[5:0];
						`CPE_REG_CONTROL1:  gen_control1 <= wr_data[7:0];
						`CPE_REG_RISE_EN:   rise_source_enables <= wr_data[7:0];
						`CPE_REG_FALL_EN:   fall_source_enables <= wr_data[7:0];
						`CPE_REG_RISE_EDGE: rise_source_edge_modes <= wr_data[7:0];
						`CPE_REG_FALL_EDGE: fall_source_edge_modes <= wr_data[7:0];
						`CPE_REG_STEERING:  steering_bits <= wr_data[7:0];
						`CPE_REG_RISE_DB:   rise_deadband_count <= wr_data[5:0];
						`CPE_REG_FALL_DB:   fall_deadband_count <= wr_data[5:0];
						`CPE_REG_STATUS:    ;
						default:            s_axi_bresp <= `CPE_RESP_SLVERR;
					endcase
				end
				else if (wr_addr > `CPE_REG_STATUS || wr_addr[1:0] != 2'h0)
					s_axi_bresp <= `CPE_RESP_SLVERR;
			end
		end
	end

	always @*
	begin
		next_rresp = `CPE_RESP_OKAY;
		case (s_axi_araddr)
			`CPE_REG_CONTROL0:  next_rdata = {26'h0, gen_control0};
			`CPE_REG_CONTROL1:  next_rdata = {24'h0, gen_control1};
			`CPE_REG_RISE_EN:   next_rdata = {24'h0, rise_source_enables};
			`CPE_REG_FALL_EN:   next_rdata = {24'h0, fall_source_enables};
			`CPE_REG_RISE_EDGE: next_rdata = {24'h0, rise_source_edge_modes};
			`CPE_REG_FALL_EDGE: next_rdata = {24'h0, fall_source_edge_modes};
			`CPE_REG_STEERING:  next_rdata = {24'h0, steering_bits};
			`CPE_REG_RISE_DB:   next_rdata = {26'h0, rise_deadband_count};
			`CPE_REG_FALL_DB:   next_rdata = {26'h0, fall_deadband_count};
			`CPE_REG_STATUS:    next_rdata = {22'h0, pp_phase, dir_busy,
				rdb_busy, fdb_busy, comp, prim, out_q};
			default:
			begin
				next_rdata = 32'h00000000;
				next_rresp = `CPE_RESP_SLVERR;
			end
		endcase
	end

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= `CPE_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= next_rdata;
			s_axi_rresp  <= next_rresp;
		end
		else if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end
endmodule

// ---- verif/cpe_far_side.sv ----
`timescale 1ns/1ps
module cpe_far_side (
	input  wire aclk,
	input  wire aresetn,
	input  wire slow,
	input  wire rise_event_pulse,
	input  wire fall_event_pulse,
	output wire rise_phase_fire,
	output wire fall_phase_fire,
	output reg  internal_fast_osc
);
	reg       rise_q;
	reg       fall_q;
	reg [2:0] div;
	// ==========================================
	// zero phase delay: pass at once or one cycle on
	assign rise_phase_fire = slow ? rise_q : rise_event_pulse;
	assign fall_phase_fire = slow ? fall_q : fall_event_pulse;
	// ==========================================
	// oscillator tick once every five cycles
	always @(posedge aclk)
	begin
		rise_q <= aresetn & rise_event_pulse;
		fall_q <= aresetn & fall_event_pulse;
		div <= (div == 3'h4 || !aresetn) ? 3'h0 : div + 3'h1;
		internal_fast_osc <= (div == 3'h4);
	end
endmodule

// ---- verif/cpe_checker_asserts.sv ----
`timescale 1ns/1ps
module cpe_checker (
	input wire        aclk,
	input wire        aresetn,
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire        s_axi_wvalid,
	input wire        s_axi_wready,
	input wire [1:0]  s_axi_bresp,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire        rise_event_pulse,
	input wire        fall_event_pulse,
	input wire        rise_phase_fire,
	input wire        fall_phase_fire,
	input wire        start_fall_blanking,
	input wire        start_rise_blanking,
	input wire        shutdown_active,
	input wire [3:0]  out_hiz
);
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// ==========================================
	// event link
	rise_one_a: assert property (rise_event_pulse |=> !rise_event_pulse)
		else $error("rise event pulse held two cycles");
	fall_one_a: assert property (fall_event_pulse |=> !fall_event_pulse)
		else $error("fall event pulse held two cycles");
	fall_blank_a: assert property (start_fall_blanking |-> $past(rise_phase_fire))
		else $error("fall blanking start without rise fire");
	rise_blank_a: assert property (start_rise_blanking |-> $past(fall_phase_fire))
		else $error("rise blanking start without fall fire");
	hiz_cause_a: assert property (|out_hiz |-> $past(shutdown_active))
		else $error("high-Z output outside shutdown");
	// ==========================================
	// register bus
	bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	ar_ready_a: assert property (s_axi_arready == !s_axi_rvalid)
		else $error("read address ready wrong");
	busy_refuse_a: assert property (s_axi_bvalid
		|-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid)
		else $error("read answer late");
	write_answer_a: assert property (s_axi_awvalid && s_axi_awready
		&& s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
		else $error("write answer late");
endmodule
bind cpe_top cpe_checker cpe_checker_inst (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.rise_event_pulse(rise_event_pulse), .fall_event_pulse(fall_event_pulse),
	.rise_phase_fire(rise_phase_fire), .fall_phase_fire(fall_phase_fire),
	.start_fall_blanking(start_fall_blanking),
	.start_rise_blanking(start_rise_blanking),
	.shutdown_active(shutdown_active), .out_hiz(out_hiz));

// ---- verif/complementary_pwm_event_deadband_bench.sv ----
`timescale 1ns/1ps
`include "cpe_consts.vh"
module complementary_pwm_event_deadband_bench;
	reg         aclk = 1'b0;
	reg         aresetn = 1'b0;
	reg  [7:0]  awaddr = 8'h00, araddr = 8'h00, rise_src = 8'h00, fall_src = 8'h00;
	reg  [31:0] wdata = 32'h0;
	reg  [3:0]  wstrb = 4'hF;
	reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
	reg         rready = 1'b0, blank_r = 1'b0, shut = 1'b0, slow = 1'b0;
	reg  [1:0]  ovr = 2'h0;
	wire        awready, wready, bvalid, arready, rvalid, ref_clk, osc;
	wire        out_a, out_b, out_c, out_d, rpulse, fpulse, rfire, ffire;
	wire [1:0]  bresp, rresp;
	wire [31:0] rdata;
	wire [3:0]  hiz;
	wire [3:0]  obs = {fpulse, rpulse, out_b, out_a};
	integer     err_total = 0;
	integer     n_tests = 0;
	integer     i, c, e, n;
	reg  [31:0] rnd = 32'h87FA035C;
	reg  [31:0] rd;
	reg  [1:0]  rsp;

	always #5 aclk = ~aclk;
	cpe_top cpe_top_inst (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .rise_sources(rise_src),
		.fall_sources(fall_src), .internal_fast_osc(osc),
		.blank_rise_inputs(blank_r), .blank_fall_inputs(1'b0),
		.rise_phase_fire(rfire), .fall_phase_fire(ffire),
		.shutdown_active(shut), .override_ac(ovr), .override_bd(ovr),
		.out_a(out_a), .out_b(out_b), .out_c(out_c), .out_d(out_d),
		.out_hiz(hiz), .gen_ref_clock(ref_clk), .rise_event_pulse(rpulse),
		.fall_event_pulse(fpulse), .start_fall_blanking(),
		.start_rise_blanking());
	cpe_far_side cpe_far_side_inst (.aclk(aclk), .aresetn(aresetn),
		.slow(slow), .rise_event_pulse(rpulse), .fall_event_pulse(fpulse),
		.rise_phase_fire(rfire), .fall_phase_fire(ffire),
		.internal_fast_osc(osc));

	// ==========================================
	// helpers
	function [31:0] nxt(input [31:0] x);
		nxt = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	task results;
	begin
		$display("mismatches %0d in %0d checks", err_total, n_tests);
		if (err_total == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	end
	endtask
	task chk(input [31:0] got, input [31:0] exp);
	begin
		n_tests = n_tests + 1;
		if (got !== exp)
		begin
			err_total = err_total + 1;
			$display("ERROR at %0t got %h expected %h", $time, got, exp);
		end
	end
	endtask
	task cyc(input integer k);
		repeat (k) @(posedge aclk);
	endtask
	task wr(input [7:0] a, input [31:0] d);
		integer k;
	begin
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (k = 0; k < 40 && bready !== 1'b0 || k == 0; k = k + 1)
		begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid && bready)
			begin
				rsp = bresp;
				bready <= 1'b0;
				k = 99;
			end
		end
		if (k < 99)
			begin err_total = err_total + 1; results; end
	end
	endtask
	task rdr(input [7:0] a);
		integer k;
	begin
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (k = 0; k < 40; k = k + 1)
		begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid && rready)
			begin
				rd = rdata;
				rsp = rresp;
				rready <= 1'b0;
				k = 99;
			end
		end
		if (k < 99)
			begin err_total = err_total + 1; results; end
	end
	endtask
	task wbit(input integer b, output integer cnt);
	begin
		cnt = 0;
		@(posedge aclk);
		while (obs[b] !== 1'b1 && cnt < 300)
		begin
			cnt = cnt + 1;
			@(posedge aclk);
		end
		if (cnt >= 300)
			begin err_total = err_total + 1; results; end
	end
	endtask
	task fire(input f);
	begin
		@(posedge aclk);
		if (f)
			fall_src <= 8'h02;
		else
			rise_src <= 8'h01;
		@(posedge aclk);
		rise_src <= 8'h00;
		fall_src <= 8'h00;
	end
	endtask

	// ==========================================
	// main sequence
	initial
	begin
		cyc(2);
		aresetn <= 1'b1;
		for (i = 0; i < 9; i = i + 1)
			begin rdr(8'h04 * i[3:0]); chk(rd, 0); chk(rsp, `CPE_RESP_OKAY); end
		rdr(8'h28); chk(rd, 0); chk(rsp, `CPE_RESP_SLVERR);
		rdr(8'h02); chk(rsp, `CPE_RESP_SLVERR);
		wr(8'h30, 32'h1); chk(rsp, `CPE_RESP_SLVERR);
		wr(8'h24, 32'hFF); chk(rsp, `CPE_RESP_OKAY);
		for (i = 2; i < 9; i = i + 1)
		begin
			rnd = nxt(rnd);
			wr(8'h04 * i[3:0], rnd);
			rdr(8'h04 * i[3:0]);
			chk(rd, rnd & ((i > 6) ? 32'h3F : 32'hFF));
		end
		wstrb <= 4'h0;
		wr(8'h20, 32'h15);
		wstrb <= 4'hF;
		rdr(8'h20); chk(rd, rnd & 32'h3F);
		wr(8'h08, 32'h01); wr(8'h10, 32'h01);
		wr(8'h0C, 32'h02); wr(8'h14, 32'h02);
		wr(8'h00, 32'h08);
		cyc(3); chk({out_b, out_a}, 2'b10);
		wr(8'h04, 32'h10);
		cyc(3); chk(out_a, 1'b1);
		wr(8'h04, 32'h00); wr(8'h00, 32'h09);
		cyc(3); chk({out_b, out_a}, 2'b10);
		for (i = 0; i < 6; i = i + 1)
		begin
			rnd = nxt(rnd);
			n = (i < 2) ? i : rnd[5:0];
			wr(8'h04, (i % 2) ? 32'h0 : 32'h3);
			wr(8'h1C, n);
			wr(8'h20, n);
			slow <= i[1];
			e = ((i % 2) ? (n * 5 + 9) / 10 : n) + 2 + i[1];
			fire(0); wbit(2, c); wbit(0, c);
			chk(c + 1, e); chk(out_b, 1'b0);
			fire(1); wbit(3, c); wbit(1, c);
			chk(c + 1, e); chk(out_a, 1'b0);
		end
		slow <= 1'b0;
		wr(8'h04, 32'h3); wr(8'h1C, 32'd30); wr(8'h20, 32'd4);
		fire(0); wbit(2, c); cyc(3); fire(1); wbit(3, c); wbit(1, c);
		chk(c + 1, 6); cyc(40); chk({out_b, out_a}, 2'b10);
		wr(8'h10, 32'hFF);
		for (i = 0; i < 8; i = i + 1)
		begin
			rnd = nxt(rnd);
			wr(8'h08, rnd[7:0]);
			rise_src <= rnd[15:8];
			c = 0;
			repeat (6) begin @(posedge aclk); c = c + rpulse; end
			chk(c, |(rnd[7:0] & rnd[15:8]));
			rise_src <= 8'h00;
			cyc(2);
		end
		wr(8'h08, 32'h01);
		for (i = 0; i < 2; i = i + 1)
		begin
			wr(8'h10, i);
			blank_r <= 1'b1;
			rise_src <= 8'h01;
			cyc(4);
			blank_r <= 1'b0;
			c = 0;
			repeat (8) begin @(posedge aclk); c = c + rpulse; end
			chk(c, (i == 0) ? 1 : 0);
			rise_src <= 8'h00;
			cyc(2);
		end
		fire(1); cyc(4);
		for (i = 0; i < 4; i = i + 1)
		begin
			shut <= 1'b1;
			ovr <= i[1:0];
			cyc(3);
			chk(hiz, (i == 1) ? 4'hF : 4'h0);
			if (i != 1)
				chk({out_b, out_a}, (i == 0) ? 2 : (i == 2) ? 0 : 3);
		end
		shut <= 1'b0;
		wr(8'h00, 32'h05);
		fire(0);
		cyc(4);
		chk({out_d, out_a}, 2'b11);
		wr(8'h00, 32'h07);
		wbit(1, c);
		chk(c + 1, 6);
		wr(8'h00, 32'h0B);
		fire(0);
		cyc(3);
		chk({out_d, out_c, out_b, out_a}, 4'hA);
		rnd = nxt(rnd);
		wr(8'h00, 32'h0); wr(8'h18, {rnd[3:0], 4'h0});
		cyc(3); chk({out_d, out_c, out_b, out_a}, rnd[3:0]);
		for (i = 0; i < 4; i = i + 1)
		begin
			wr(8'h00, i << 4);
			cyc(4);
			c = 0;
			repeat (40) begin @(posedge aclk); c = c + ref_clk; end
			chk(c, (i == 0) ? 40 : (i == 1) ? 10 : 8);
		end
		results;
	end
endmodule
